// *** lsd_pkg.sv ***
// Package of offsets, field layouts, reset values and types for the LED slot drive configuration bank
package lsd_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] LSD_ADDR_ROUTING = 8'h14;
    localparam logic [7:0] LSD_ADDR_LED3 = 8'h22;
    localparam logic [7:0] LSD_ADDR_LED1 = 8'h23;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] LSD_RST_ROUTING = 16'h0541;
    localparam logic [15:0] LSD_RST_LED3 = 16'h3000;
    localparam logic [15:0] LSD_RST_LED1 = 16'h1000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int LSD_A_EMIT_LO = 0;
    localparam int LSD_B_EMIT_LO = 2;
    localparam int LSD_A_DIODE_LO = 4;
    localparam int LSD_B_DIODE_LO = 8;
    localparam int LSD_SCALE_BIT = 13;
    localparam int LSD_EDGE_LO = 4;
    localparam int LSD_COARSE_LO = 0;

    // ****************************************************************
    // Current arithmetic, fixed point
    // ****************************************************************
    // Coarse factor in tenths of mA: 50.3 + 19.8 * code
    localparam logic [11:0] LSD_COARSE_BASE = 12'h1f7;
    localparam logic [11:0] LSD_COARSE_STEP = 12'h0c6;
    // Fine factor in thousandths: 0.74 + 0.022 * code
    localparam logic [10:0] LSD_FINE_BASE = 11'h2e4;
    localparam logic [10:0] LSD_FINE_STEP = 11'h016;
    // Scale in tenths: 0.1 + 0.9 * bit
    localparam logic [3:0] LSD_SCALE_BASE = 4'h1;
    localparam logic [3:0] LSD_SCALE_STEP = 4'h9;
    localparam int LSD_PEAK_W = 26;

    // ****************************************************************
    // Emitter choice encoding
    // ****************************************************************
    typedef enum logic [1:0] {
        LSD_EMIT_DIODE = 2'b00,
        LSD_EMIT_LED1 = 2'b01,
        LSD_EMIT_LED2 = 2'b10,
        LSD_EMIT_LED3 = 2'b11
    } lsd_emit_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } lsd_req_t;

    typedef struct packed {
        logic [1:0] emitterChoice;
        logic [3:0] diodeRoute;
        logic [2:0] ledPulse;
        logic diodePulseConnect;
    } lsd_slot_t;

endpackage

// *** lsd_peak_calc.sv ***
// Peak target current of the third LED driver from coarse, fine and scale settings
`timescale 1ns/10ps
`default_nettype none
module lsd_peak_calc
    import lsd_pkg::*;
(
    // Settings
    input wire logic [3:0] coarseCode,
    input wire logic [4:0] fineCode,
    input wire logic scaleBit,
    // Result in units of 1e-5 mA
    output logic [lsd_pkg::LSD_PEAK_W-1:0] peakCurrent
);
    import lsd_pkg::*;

    logic [11:0] coarseFactor;
    logic [10:0] fineFactor;
    logic [3:0] scaleFactor;
    logic [LSD_PEAK_W-1:0] product;

    always_comb begin
        coarseFactor = LSD_COARSE_BASE + 12'(LSD_COARSE_STEP * 12'(coarseCode));
        fineFactor = LSD_FINE_BASE + 11'(LSD_FINE_STEP * 11'(fineCode));
        scaleFactor = scaleBit ? (LSD_SCALE_BASE + LSD_SCALE_STEP) : LSD_SCALE_BASE;
        product = LSD_PEAK_W'(26'(coarseFactor) * 26'(fineFactor) * 26'(scaleFactor));
        peakCurrent = product;
    end
endmodule
`default_nettype wire

// *** lsd_config_regs.sv ***
// LED slot routing and LED driver configuration register bank
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Slot A emitter choice, bits 1:0, reset 1
// - Slot B emitter choice, bits 3:2, reset 0
// - Slot B diode route, bits 11:8, reset 5
// - Slot A diode route, bits 7:4, reset 4
// - LED3 scale bit 13, full or tenth
// - LED1 scale bit 13, resets to zero
// - LED3 edge rate, bits 6:4, reset 0
// - LED3 coarse current, bits 3:0
// - LED3 peak is coarse times fine times scale
module lsd_config_regs
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access port
    input wire lsd_pkg::lsd_req_t regReq,
    output logic [15:0] regRdData,
    output logic regRdValid,
    // Fine adjust code held elsewhere
    input wire logic [4:0] fineAdjustCode,
    // Slot sequencer settings
    output lsd_pkg::lsd_slot_t firstSlot,
    output lsd_pkg::lsd_slot_t secondSlot,
    // LED driver settings
    output logic third_emitter_current_scale,
    output logic [2:0] third_emitter_edge_rate,
    output logic [3:0] third_emitter_coarse_current,
    output logic first_emitter_current_scale,
    output logic [lsd_pkg::LSD_PEAK_W-1:0] thirdEmitterPeak
);
    import lsd_pkg::*;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // One-hot LED pulse enables for an emitter choice
    function automatic logic [2:0] ledPulseOf(input logic [1:0] choice);
        logic [2:0] res;
        res = 3'h0;
        case (lsd_emit_t'(choice))
            LSD_EMIT_LED1: res = 3'h1;
            LSD_EMIT_LED2: res = 3'h2;
            LSD_EMIT_LED3: res = 3'h4;
            default: res = 3'h0;
        endcase
        return res;
    endfunction

    // Builds the settings of one time slot from its fields
    function automatic lsd_slot_t slotOf(input logic [1:0] choice, input logic [3:0] route);
        lsd_slot_t s;
        s.emitterChoice = choice;
        s.diodeRoute = route;
        s.ledPulse = ledPulseOf(choice);
        s.diodePulseConnect = (lsd_emit_t'(choice) == LSD_EMIT_DIODE);
        return s;
    endfunction

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [15:0] routing_r;
    logic [15:0] routing_nxt;
    logic [15:0] led3Drive_r;
    logic [15:0] led3Drive_nxt;
    logic [15:0] led1Drive_r;
    logic [15:0] led1Drive_nxt;

    // Whole words are stored, reserved bits included, so reads echo writes.
    // Reserved bits are not forced: software is expected to write them as
    // documented, and the driver logic never looks at them.
    always_comb begin
        routing_nxt = routing_r;
        led3Drive_nxt = led3Drive_r;
        led1Drive_nxt = led1Drive_r;
        if (regReq.wr) begin
            case (regReq.addr)
                LSD_ADDR_ROUTING: routing_nxt = regReq.wdata;
                LSD_ADDR_LED3: led3Drive_nxt = regReq.wdata;
                LSD_ADDR_LED1: led1Drive_nxt = regReq.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            routing_r <= LSD_RST_ROUTING;
            led3Drive_r <= LSD_RST_LED3;
            led1Drive_r <= LSD_RST_LED1;
        end else begin
            routing_r <= routing_nxt;
            led3Drive_r <= led3Drive_nxt;
            led1Drive_r <= led1Drive_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [15:0] rdData_nxt;
    logic rdValid_nxt;
    logic [15:0] rdData_r;
    logic rdValid_r;

    // Unmapped addresses read as zero
    always_comb begin
        rdValid_nxt = regReq.rd;
        rdData_nxt = rdData_r;
        if (regReq.rd) begin
            case (regReq.addr)
                LSD_ADDR_ROUTING: rdData_nxt = routing_r;
                LSD_ADDR_LED3: rdData_nxt = led3Drive_r;
                LSD_ADDR_LED1: rdData_nxt = led1Drive_r;
                default: rdData_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData_r <= 16'h0000;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    logic [1:0] first_slot_emitter_choice;
    logic [1:0] second_slot_emitter_choice;
    logic [3:0] first_slot_diode_route;
    logic [3:0] second_slot_diode_route;

    always_comb begin
        first_slot_emitter_choice = routing_nxt[LSD_A_EMIT_LO +: 2];
        second_slot_emitter_choice = routing_nxt[LSD_B_EMIT_LO +: 2];
        first_slot_diode_route = routing_nxt[LSD_A_DIODE_LO +: 4];
        second_slot_diode_route = routing_nxt[LSD_B_DIODE_LO +: 4];
    end

    // ****************************************************************
    // Peak current of the third driver
    // ****************************************************************
    logic [LSD_PEAK_W-1:0] peakCalc;

    lsd_peak_calc u_peak (
        .coarseCode(led3Drive_nxt[LSD_COARSE_LO +: 4]),
        .fineCode(fineAdjustCode),
        .scaleBit(led3Drive_nxt[LSD_SCALE_BIT]),
        .peakCurrent(peakCalc)
    );

    // ****************************************************************
    // Registered settings outputs
    // ****************************************************************
    // Computed from the next register values so the outputs follow a write
    // on the same edge that stores it, with no extra cycle of lag.
    lsd_slot_t firstSlot_r;
    lsd_slot_t firstSlot_nxt;
    lsd_slot_t secondSlot_r;
    lsd_slot_t secondSlot_nxt;
    logic led3Scale_r;
    logic led3Scale_nxt;
    logic [2:0] led3Edge_r;
    logic [2:0] led3Edge_nxt;
    logic [3:0] led3Coarse_r;
    logic [3:0] led3Coarse_nxt;
    logic led1Scale_r;
    logic led1Scale_nxt;
    logic [LSD_PEAK_W-1:0] peak_r;
    logic [LSD_PEAK_W-1:0] peak_nxt;

    always_comb begin
        firstSlot_nxt = slotOf(first_slot_emitter_choice, first_slot_diode_route);
        secondSlot_nxt = slotOf(second_slot_emitter_choice, second_slot_diode_route);
        led3Scale_nxt = led3Drive_nxt[LSD_SCALE_BIT];
        led3Edge_nxt = led3Drive_nxt[LSD_EDGE_LO +: 3];
        led3Coarse_nxt = led3Drive_nxt[LSD_COARSE_LO +: 4];
        led1Scale_nxt = led1Drive_nxt[LSD_SCALE_BIT];
        peak_nxt = peakCalc;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            firstSlot_r <= slotOf(LSD_RST_ROUTING[LSD_A_EMIT_LO +: 2], LSD_RST_ROUTING[LSD_A_DIODE_LO +: 4]);
            secondSlot_r <= slotOf(LSD_RST_ROUTING[LSD_B_EMIT_LO +: 2], LSD_RST_ROUTING[LSD_B_DIODE_LO +: 4]);
            led3Scale_r <= LSD_RST_LED3[LSD_SCALE_BIT];
            led3Edge_r <= LSD_RST_LED3[LSD_EDGE_LO +: 3];
            led3Coarse_r <= LSD_RST_LED3[LSD_COARSE_LO +: 4];
            led1Scale_r <= LSD_RST_LED1[LSD_SCALE_BIT];
            peak_r <= '0;
        end else begin
            firstSlot_r <= firstSlot_nxt;
            secondSlot_r <= secondSlot_nxt;
            led3Scale_r <= led3Scale_nxt;
            led3Edge_r <= led3Edge_nxt;
            led3Coarse_r <= led3Coarse_nxt;
            led1Scale_r <= led1Scale_nxt;
            peak_r <= peak_nxt;
        end
    end

    assign firstSlot = firstSlot_r;
    assign secondSlot = secondSlot_r;
    assign third_emitter_current_scale = led3Scale_r;
    assign third_emitter_edge_rate = led3Edge_r;
    assign third_emitter_coarse_current = led3Coarse_r;
    assign first_emitter_current_scale = led1Scale_r;
    assign thirdEmitterPeak = peak_r;

endmodule
`default_nettype wire

// *** lsd_config_regs_asserts.sv ***
// Checker of the LED slot drive configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module lsd_config_regs_asserts
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire lsd_pkg::lsd_req_t regReq,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    input wire logic [4:0] fineAdjustCode,
    // Settings
    input wire lsd_pkg::lsd_slot_t firstSlot,
    input wire lsd_pkg::lsd_slot_t secondSlot,
    input wire logic third_emitter_current_scale,
    input wire logic [2:0] third_emitter_edge_rate,
    input wire logic [3:0] third_emitter_coarse_current,
    input wire logic first_emitter_current_scale,
    input wire logic [lsd_pkg::LSD_PEAK_W-1:0] thirdEmitterPeak
);
    import lsd_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic wrRt = regReq.wr && regReq.addr == LSD_ADDR_ROUTING;
    wire logic wr3 = regReq.wr && regReq.addr == LSD_ADDR_LED3;
    wire logic wr1 = regReq.wr && regReq.addr == LSD_ADDR_LED1;
    wire logic mapped = regReq.addr inside {LSD_ADDR_ROUTING, LSD_ADDR_LED3, LSD_ADDR_LED1};

    // ****************************************************************
    // Properties
    // ****************************************************************
    a_read_answered: assert property (regReq.rd |=> regRdValid)
        else $error("read not answered");
    a_valid_needs_read: assert property (!regReq.rd |=> !regRdValid)
        else $error("read answer without request");
    a_unmapped_reads_zero: assert property (regReq.rd && !mapped |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_slot_a_choice: assert property (wrRt |=> firstSlot.emitterChoice == $past(regReq.wdata[1:0]))
        else $error("slot A emitter choice wrong");
    a_slot_b_choice: assert property (wrRt |=> secondSlot.emitterChoice == $past(regReq.wdata[3:2]))
        else $error("slot B emitter choice wrong");
    a_slot_b_route: assert property (wrRt |=> secondSlot.diodeRoute == $past(regReq.wdata[11:8]))
        else $error("slot B diode route wrong");
    a_slot_a_route: assert property (wrRt |=> firstSlot.diodeRoute == $past(regReq.wdata[7:4]))
        else $error("slot A diode route wrong");
    a_slot_a_decode: assert property (firstSlot.ledPulse == 3'((4'h1 << firstSlot.emitterChoice) >> 1)
        && firstSlot.diodePulseConnect == (firstSlot.emitterChoice == 2'h0))
        else $error("slot A pulse decode wrong");
    a_led3_fields: assert property (wr3 |=> {third_emitter_current_scale,
        third_emitter_edge_rate, third_emitter_coarse_current} == $past({regReq.wdata[13], regReq.wdata[6:0]}))
        else $error("LED3 settings wrong");
    a_led1_scale: assert property (wr1 |=> first_emitter_current_scale == $past(regReq.wdata[13]))
        else $error("LED1 scale wrong");
    a_peak_formula: assert property ($past(rst_n) |-> thirdEmitterPeak ==
        (26'h1f7 + 26'h0c6 * third_emitter_coarse_current) * (26'h2e4 + 26'h016 * $past(fineAdjustCode)) *
        (third_emitter_current_scale ? 26'h00a : 26'h001))
        else $error("LED3 peak current wrong");
    c_routing_write: cover property (wrRt);
    c_unmapped_read: cover property (regReq.rd && !mapped);
    c_led3_low_power: cover property (wr3 && !regReq.wdata[13]);
endmodule

bind lsd_config_regs lsd_config_regs_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .fineAdjustCode(fineAdjustCode),
    .firstSlot(firstSlot), .secondSlot(secondSlot), .third_emitter_current_scale(third_emitter_current_scale),
    .third_emitter_edge_rate(third_emitter_edge_rate), .third_emitter_coarse_current(third_emitter_coarse_current),
    .first_emitter_current_scale(first_emitter_current_scale), .thirdEmitterPeak(thirdEmitterPeak));
`default_nettype wire

// *** tb_led_slot_drive_config.sv ***
// Self-checking testbench of the LED slot drive configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb_led_slot_drive_config;
    import lsd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    lsd_req_t regReq = '0;
    logic [4:0] fineAdjustCode = 5'h00;
    logic [15:0] regRdData;
    logic regRdValid;
    lsd_slot_t firstSlot;
    lsd_slot_t secondSlot;
    logic s3;
    logic [2:0] e3;
    logic [3:0] c3;
    logic s1;
    logic [LSD_PEAK_W-1:0] peak;
    int err_total = 0;
    int compares = 0;

    lsd_config_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .fineAdjustCode(fineAdjustCode), .firstSlot(firstSlot),
        .secondSlot(secondSlot), .third_emitter_current_scale(s3), .third_emitter_edge_rate(e3),
        .third_emitter_coarse_current(c3), .first_emitter_current_scale(s1), .thirdEmitterPeak(peak));

    always #12.5 clk_sys = ~clk_sys;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task chk(input string what, input logic [25:0] exp, input logic [25:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    function automatic logic [25:0] pk(input logic [3:0] c, input logic [4:0] f, input logic s);
        return (26'h1f7 + 26'h0c6 * c) * (26'h2e4 + 26'h016 * f) * (s ? 26'h00a : 26'h001);
    endfunction

    function automatic lsd_slot_t slot(input logic [1:0] c, input logic [3:0] r);
        return '{c, r, 3'((4'h1 << c) >> 1), c == 2'h0};
    endfunction

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_sys);
        regReq.wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk_sys);
        regReq.addr = a;
        regReq.rd = 1'b1;
        @(negedge clk_sys);
        regReq.rd = 1'b0;
        chk("regRdValid", 26'(1'b1), 26'(regRdValid));
        chk("regRdData", 26'(exp), 26'(regRdData));
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        chk("firstSlot", 26'(slot(2'h1, 4'h4)), 26'(firstSlot));
        chk("secondSlot", 26'(slot(2'h0, 4'h5)), 26'(secondSlot));
        chk("led3 settings", 26'(8'h80), 26'({s3, e3, c3}));
        chk("led1 scale", 26'(1'b0), 26'(s1));
        chk("peak", pk(4'h0, 5'h00, 1'b1), peak);
        rd(LSD_ADDR_ROUTING, 16'h0541);
        rd(LSD_ADDR_LED3, 16'h3000);
        rd(LSD_ADDR_LED1, 16'h1000);
    endtask

    task t_slots;
        for (int k = 0; k < 4; k++) begin
            wr(LSD_ADDR_ROUTING, {4'h0, 4'(k + 8), 4'(k + 2), 2'(3 - k), 2'(k)});
            chk("firstSlot", 26'(slot(2'(k), 4'(k + 2))), 26'(firstSlot));
            chk("secondSlot", 26'(slot(2'(3 - k), 4'(k + 8))), 26'(secondSlot));
        end
        wr(LSD_ADDR_ROUTING, 16'h0b53);
        wr(8'h15, 16'h0000);
        rd(LSD_ADDR_ROUTING, 16'h0b53);
        rd(8'h15, 16'h0000);
    endtask

    task t_led3;
        fineAdjustCode = 5'h1f;
        wr(LSD_ADDR_LED3, 16'h3075);
        chk("led3 settings", 26'(8'hf5), 26'({s3, e3, c3}));
        chk("peak", pk(4'h5, 5'h1f, 1'b1), peak);
        wr(LSD_ADDR_LED3, 16'h100f);
        chk("led3 settings", 26'(8'h0f), 26'({s3, e3, c3}));
        chk("peak", pk(4'hf, 5'h1f, 1'b0), peak);
        fineAdjustCode = 5'h0a;
        @(negedge clk_sys);
        chk("peak", pk(4'hf, 5'h0a, 1'b0), peak);
        rd(LSD_ADDR_LED3, 16'h100f);
    endtask

    task t_led1;
        wr(LSD_ADDR_LED1, 16'h3000);
        chk("led1 scale", 26'(1'b1), 26'(s1));
        wr(LSD_ADDR_LED1, 16'h1000);
        chk("led1 scale", 26'(1'b0), 26'(s1));
        chk("led3 coarse", 26'(4'hf), 26'(c3));
        wr(LSD_ADDR_LED1, 16'h307f);
        rd(LSD_ADDR_LED1, 16'h307f);
    endtask

    // Reset in mid-run must bring every word back to its reset value
    task t_rerun;
        fineAdjustCode = 5'h00;
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset();
    endtask

    task wrap_up;
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_slots();
        t_led3();
        t_led1();
        t_rerun();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        $display("[ERR] run time expected %0d seen %0d", 5000, 5000);
        err_total++;
        wrap_up();
    end
endmodule
`default_nettype wire
